// ---- pkg/ubc_pkg.sv ----
// Shared constants and types for the serial channel core
// Behaviour
// - Oscillator divided by sixteen, then by divisor 1..65535, gives the 16X clock.
// - Divisor high byte forms upper eight bits, low byte the lower eight.
// - One baud generator clocks both transmitter and receiver.
// - Host register access works with the oscillator stopped.
// - Transmitter holds each serial bit for sixteen 16X clocks.
// - Frame is start low, data bits, optional parity, then stop bits.
// - Data goes out least significant bit first.
// - With FIFO on, each holding write pushes into the sixteen-entry FIFO unless it is full.
// - Without FIFO, holding-empty sets when the byte moves to the shifter.
// - Holding-empty raises transmit interrupt only when its enable is set.
// - Without FIFO, transmitter-empty sets once the shifter is done.
// - In FIFO mode holding-empty sets whenever the transmit FIFO is empty.
// - In FIFO mode transmitter-empty needs FIFO and shifter both empty.
// - Falling edge starts count; after eight clocks start must still be low.
// - Every later bit is sampled once at its centre.
// - Each stored byte carries error tags; a read shows the next byte's tags.
// - Receive ready fires per character or at trigger level, gated by enable.
// - Eight-bit receive shifter feeds a sixteen-entry FIFO headed by holding.
// - Word length setting selects 5 to 8 data bits both ways.
// - A holding read returns the oldest received character.
package ubc_pkg;
  localparam int OSC_PRESCALE = 16;
  localparam int BIT_TICKS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_ENTRY_W = 11;
  localparam int TO_WORDS = 4;
  localparam int TO_EXTRA_BITS = 12;
  localparam logic [3:0] START_CHECK = 4'h7;
  localparam logic [3:0] BIT_LAST = 4'hf;
  // Receive entry tag positions
  localparam int TAG_PAR = 8;
  localparam int TAG_FRM = 9;
  localparam int TAG_BRK = 10;
  // Interrupt enable bits
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  // Interrupt status codes
  localparam logic [3:0] IS_NONE = 4'h1;
  localparam logic [3:0] IS_TXEMPTY = 4'h2;
  localparam logic [3:0] IS_RXDATA = 4'h4;
  localparam logic [3:0] IS_TIMEOUT = 4'hc;
  // Receive trigger levels
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PARITY = 3'b011, TX_STOP = 3'b100
  } ubc_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PARITY = 3'b011, RX_STOP = 3'b100
  } ubc_rx_state_t;
endpackage

// ---- pkg/ubc_fifo_if.sv ----
// Push and pop signals between the core and a FIFO store
`timescale 1ns/1ps
interface ubc_fifo_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
);
  localparam int CW = $clog2(DEPTH + 1);
  logic push;
  logic [WIDTH-1:0] pushData;
  logic pop;
  logic [WIDTH-1:0] popData;
  logic [CW-1:0] count;
  logic empty;
  logic full;
  modport store(input push, pushData, pop,
                output popData, count, empty, full);
  modport user(output push, pushData, pop,
               input popData, count, empty, full);
endinterface

// ---- hw/ubc_fifo.sv ----
// FIFO store with registered head output
`timescale 1ns/1ps
module ubc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstN,
  input wire logic ce,
  ubc_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW-1:0] nextRd;
  logic [CW-1:0] cnt;

  assign nextRd = port.pop ? rdPtr + 1'b1 : rdPtr;
  assign port.count = cnt;
  assign port.empty = (cnt == '0);
  assign port.full = (cnt == CW'(DEPTH));

  // Storage array, no reset
  always_ff @(posedge ref_clk) begin
    if (ce && port.push) begin
      mem[wrPtr] <= port.pushData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr <= '0;
      rdPtr <= '0;
      cnt <= '0;
    end else if (ce) begin
      if (port.push) wrPtr <= wrPtr + 1'b1;
      rdPtr <= nextRd;
      cnt <= cnt + CW'(port.push) - CW'(port.pop);
    end
  end

  // Head register, forwarded when writing the next head slot
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      port.popData <= '0;
    end else if (ce) begin
      if (port.push && wrPtr == nextRd) port.popData <= port.pushData;
      else port.popData <= mem[nextRd];
    end
  end

  countBound_a: assert property (@(posedge ref_clk) disable iff (!rstN)
    (port.push && !port.pop && ce) |=> cnt == $past(cnt) + 1'b1)
    else $error("fifo count did not follow push");
endmodule // ubc_fifo

// ---- hw/ubc_baud_gen.sv ----
// Oscillator sampler and 16X baud tick generator
`timescale 1ns/1ps
module ubc_baud_gen
  import ubc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic oscIn,
  input wire logic [15:0] divisor,
  output logic tick16,
  output logic oscOut
);
  logic osc1, osc2, osc3, oscLevel, oscRise;
  logic [3:0] preCnt;
  logic [15:0] divCnt;

  assign oscRise = !oscLevel && (osc2 == osc3) && osc3;

  // Three-stage sampler of the oscillator pin
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      osc1 <= 1'b0;
      osc2 <= 1'b0;
      osc3 <= 1'b0;
      oscLevel <= 1'b0;
      oscOut <= 1'b1;
    end else if (ce) begin
      osc1 <= oscIn;
      osc2 <= osc1;
      osc3 <= osc2;
      if (osc2 == osc3) oscLevel <= osc3;
      oscOut <= ~oscLevel;
    end
  end

  // Divide by sixteen, then by the divisor
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      preCnt <= '0;
      divCnt <= '0;
      tick16 <= 1'b0;
    end else if (ce) begin
      tick16 <= 1'b0;
      if (oscRise) begin
        preCnt <= preCnt + 1'b1;
        if (preCnt == 4'(OSC_PRESCALE - 1)) begin
          if (divisor == '0) begin
            divCnt <= '0;
          end else if (divCnt >= divisor - 1'b1) begin
            divCnt <= '0;
            tick16 <= 1'b1;
          end else begin
            divCnt <= divCnt + 1'b1;
          end
        end
      end
    end
  end

  tickRate_a: assert property (@(posedge ref_clk) disable iff (!rstN)
    tick16 |-> $past(preCnt) == 4'(OSC_PRESCALE - 1))
    else $error("16X tick not on a prescaler wrap");
endmodule // ubc_baud_gen

// ---- hw/ubc_uart_core.sv ----
// Serial channel core: baud, transmitter and receiver with FIFOs
`timescale 1ns/1ps
module ubc_uart_core
  import ubc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic oscIn,
  output logic oscOut,
  input wire logic rxIn,
  output logic txOut,
  input wire logic [7:0] divisorHighByte,
  input wire logic [7:0] divisorLowByte,
  input wire logic fifoEnable,
  input wire logic [1:0] wordLength,
  input wire logic stopBits,
  input wire logic parityEnable,
  input wire logic evenParity,
  input wire logic [1:0] rxTrigger,
  input wire logic [1:0] intEnable,
  input wire logic txWrite,
  input wire logic [7:0] txData,
  input wire logic rxRead,
  output logic [7:0] rxData,
  output logic [7:0] lineStatus,
  output logic [3:0] intStatus
);
  logic rstMeta, rstN;
  logic tick16;
  logic [15:0] divisor;
  logic [3:0] dataBits;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // Divisor and word length
  assign divisor = {divisorHighByte, divisorLowByte};
  assign dataBits = 4'h5 + {2'b00, wordLength};

  // One generator shared by both directions
  ubc_baud_gen baud_generator (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .ce(ce),
    .oscIn(oscIn),
    .divisor(divisor),
    .tick16(tick16),
    .oscOut(oscOut)
  );

  ubc_fifo_if #(.WIDTH(8), .DEPTH(DEPTH)) txf ();
  ubc_fifo_if #(.WIDTH(RX_ENTRY_W), .DEPTH(DEPTH)) rxf ();

  ubc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .ce(ce),
    .port(txf)
  );

  ubc_fifo #(.WIDTH(RX_ENTRY_W), .DEPTH(DEPTH)) rx_fifo (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .ce(ce),
    .port(rxf)
  );

  // ---------------- transmitter ----------------
  ubc_tx_state_t txState;
  logic [7:0] tx_shift_reg;
  logic [3:0] txTick;
  logic [3:0] txBitCnt;
  logic txPar;
  logic txStopCnt;
  logic txFirst;
  logic txFullEff;
  logic txHoldEmpty;
  logic txAllEmpty;

  // Holding stage is one entry deep with FIFO off
  assign txFullEff = fifoEnable ? txf.full : !txf.empty;
  assign txf.push = ce && txWrite && !txFullEff;
  assign txf.pushData = txData;
  assign txf.pop = ce && tick16 && txState == TX_IDLE && !txf.empty;
  assign txHoldEmpty = txf.empty;
  assign txAllEmpty = txf.empty && txState == TX_IDLE;

  // Frame sequencer, one bit per sixteen ticks
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      txState <= TX_IDLE;
      tx_shift_reg <= '0;
      txTick <= '0;
      txBitCnt <= '0;
      txPar <= 1'b0;
      txStopCnt <= 1'b0;
      txFirst <= 1'b0;
      txOut <= 1'b1;
    end else if (ce && tick16) begin
      if (txState == TX_IDLE) begin
        txOut <= 1'b1;
        if (!txf.empty) begin
          tx_shift_reg <= txf.popData;
          txFirst <= txf.popData[0];
          txTick <= '0;
          txOut <= 1'b0;
          txState <= TX_START;
        end
      end else begin
        txTick <= txTick + 1'b1;
        if (txTick == BIT_LAST) begin
          case (txState)
            TX_START: begin
              txOut <= tx_shift_reg[0];
              txPar <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              txBitCnt <= 4'h1;
              txState <= TX_DATA;
            end
            TX_DATA: begin
              if (txBitCnt == dataBits) begin
                txStopCnt <= 1'b0;
                if (parityEnable) begin
                  txOut <= txPar ^ ~evenParity;
                  txState <= TX_PARITY;
                end else begin
                  txOut <= 1'b1;
                  txState <= TX_STOP;
                end
              end else begin
                txOut <= tx_shift_reg[0];
                txPar <= txPar ^ tx_shift_reg[0];
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                txBitCnt <= txBitCnt + 1'b1;
              end
            end
            TX_PARITY: begin
              txOut <= 1'b1;
              txState <= TX_STOP;
            end
            TX_STOP: begin
              if (stopBits && !txStopCnt) begin
                txStopCnt <= 1'b1;
              end else begin
                txState <= TX_IDLE;
              end
            end
            default: txState <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // ---------------- receiver ----------------
  ubc_rx_state_t rxState;
  logic rxS1, rxS2, rxS3, rxLine, rxFall;
  logic [7:0] rx_shift_reg;
  logic [7:0] rxChar;
  logic [3:0] rxTick;
  logic [3:0] rxBitCnt;
  logic rxPar;
  logic rxParBit;
  logic rxFullEff;
  logic rxSampleStop;
  logic rxParErr;
  logic rxBreak;

  // Three-stage line sampler
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxS3 <= 1'b1;
      rxLine <= 1'b1;
    end else if (ce) begin
      rxS1 <= rxIn;
      rxS2 <= rxS1;
      rxS3 <= rxS2;
      if (rxS2 == rxS3) rxLine <= rxS3;
    end
  end

  assign rxFall = rxLine && (rxS2 == rxS3) && !rxS3;

  // Character alignment and tags
  assign rxChar = rx_shift_reg >> (2'd3 - wordLength);
  assign rxParErr = parityEnable && (rxParBit != (rxPar ^ ~evenParity));
  assign rxBreak = (rxChar == 8'h00) && !rxLine
                   && !(parityEnable && rxParBit);
  assign rxSampleStop = ce && tick16 && rxState == RX_STOP
                        && rxTick == BIT_LAST;
  assign rxFullEff = fifoEnable ? rxf.full : !rxf.empty;
  assign rxf.push = rxSampleStop && !rxFullEff;
  assign rxf.pushData = {rxBreak, !rxLine, rxParErr, rxChar};
  assign rxf.pop = ce && rxRead && !rxf.empty;

  // Start validation and centre sampling
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rxState <= RX_IDLE;
      rx_shift_reg <= '0;
      rxTick <= '0;
      rxBitCnt <= '0;
      rxPar <= 1'b0;
      rxParBit <= 1'b0;
    end else if (ce) begin
      if (rxState == RX_IDLE) begin
        if (rxFall) begin
          rxTick <= '0;
          rxState <= RX_START;
        end
      end else if (tick16) begin
        rxTick <= rxTick + 1'b1;
        case (rxState)
          RX_START: begin
            if (rxTick == START_CHECK) begin
              rxTick <= '0;
              rxBitCnt <= '0;
              rxPar <= 1'b0;
              rxParBit <= 1'b0;
              if (rxLine) rxState <= RX_IDLE;
              else rxState <= RX_DATA;
            end
          end
          RX_DATA: begin
            if (rxTick == BIT_LAST) begin
              rx_shift_reg <= {rxLine, rx_shift_reg[7:1]};
              rxPar <= rxPar ^ rxLine;
              rxBitCnt <= rxBitCnt + 1'b1;
              if (rxBitCnt == dataBits - 1'b1) begin
                if (parityEnable) rxState <= RX_PARITY;
                else rxState <= RX_STOP;
              end
            end
          end
          RX_PARITY: begin
            if (rxTick == BIT_LAST) begin
              rxParBit <= rxLine;
              rxState <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rxTick == BIT_LAST) rxState <= RX_IDLE;
          end
          default: rxState <= RX_IDLE;
        endcase
      end
    end
  end

  // ---------------- time-out and status ----------------
  logic [9:0] toCnt;
  logic [9:0] toLimit;
  logic [3:0] charBits;
  logic rxTimeout;
  logic rxReady;
  logic [4:0] trigLevel;

  // Frame length in bits: start, data, parity, stop
  assign charBits = 4'h2 + dataBits + {3'b000, parityEnable}
                    + {3'b000, stopBits};
  assign toLimit = 10'(({6'h00, charBits} * 10'(TO_WORDS)
                   + 10'(TO_EXTRA_BITS)) * 10'(BIT_TICKS));

  // Idle-line counter in 16X ticks
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      toCnt <= '0;
    end else if (ce) begin
      if (rxf.push || rxf.pop || rxf.empty) toCnt <= '0;
      else if (tick16 && toCnt != toLimit) toCnt <= toCnt + 1'b1;
    end
  end

  assign rxTimeout = (toCnt == toLimit) && !rxf.empty;

  always_comb begin
    case (rxTrigger)
      2'b00: trigLevel = TRIG_L0;
      2'b01: trigLevel = TRIG_L1;
      2'b10: trigLevel = TRIG_L2;
      default: trigLevel = TRIG_L3;
    endcase
  end

  // Per character without FIFO, trigger level with it
  assign rxReady = fifoEnable ? (rxf.count >= trigLevel)
                              : !rxf.empty;

  // Interrupt status, highest priority first
  always_comb begin
    if (intEnable[IE_RX] && rxTimeout) intStatus = IS_TIMEOUT;
    else if (intEnable[IE_RX] && rxReady) intStatus = IS_RXDATA;
    else if (intEnable[IE_TX] && txHoldEmpty) begin
      intStatus = IS_TXEMPTY;
    end else intStatus = IS_NONE;
  end

  // Head data and tags of the oldest byte
  assign rxData = rxf.popData[7:0];
  assign lineStatus = {1'b0, txAllEmpty, txHoldEmpty,
                       rxf.empty ? 3'h0 : rxf.popData[TAG_BRK:TAG_PAR],
                       1'b0, !rxf.empty};

  // ---------------- checks ----------------
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  txIdleHigh_a: assert property (txState == TX_IDLE |-> txOut)
    else $error("transmit line not high when idle");
  startLow_a: assert property (txState == TX_START |-> !txOut)
    else $error("start bit not low");
  bitHold_a: assert property ((ce && tick16 && txState != TX_IDLE
      && txTick != BIT_LAST) |=> txState == $past(txState) && $stable(txOut))
    else $error("transmit bit left early");
  lsbFirst_a: assert property ($rose(txState == TX_DATA)
      |-> txOut == txFirst)
    else $error("first data bit is not bit zero");
  holdFull_a: assert property (txf.push |=> !lineStatus[5])
    else $error("holding empty after write");
  allEmpty_a: assert property (lineStatus[6] |-> lineStatus[5]
      && txState == TX_IDLE)
    else $error("transmitter empty while busy");
  startCheck_a: assert property ((ce && tick16 && rxState == RX_START
      && rxTick == START_CHECK && !rxLine) |=> rxState == RX_DATA)
    else $error("valid start not accepted");
  falseStart_a: assert property ((ce && tick16 && rxState == RX_START
      && rxTick == START_CHECK && rxLine) |-> !rxf.push
      ##1 rxState == RX_IDLE && $stable(rxf.count))
    else $error("false start stored data");
  framing_a: assert property ((rxf.push && !rxLine)
      |-> rxf.pushData[TAG_FRM])
    else $error("framing error not tagged");
  rxGate_a: assert property (!intEnable[IE_RX]
      |-> intStatus != IS_RXDATA && intStatus != IS_TIMEOUT)
    else $error("receive interrupt while disabled");
  txGate_a: assert property ((intStatus == IS_TXEMPTY)
      |-> intEnable[IE_TX] && txf.empty)
    else $error("transmit interrupt without cause");
  timeout_a: assert property ($rose(rxTimeout)
      |-> $past(toCnt) == toLimit - 10'h001)
    else $error("time-out at wrong count");
  tagNext_a: assert property ((rxf.pop && rxf.count > 5'h01)
      |=> lineStatus[4:2] == rxf.popData[TAG_BRK:TAG_PAR])
    else $error("tags not from new head");
endmodule // ubc_uart_core

// ---- test/ubc_remote_model.sv ----
// Remote serial device model: frame sender and line decoder
`timescale 1ns/1ps
module ubc_remote_model (
  input wire logic txLine,
  output logic rxLine,
  input wire logic [3:0] dataBits,
  input wire logic parOn,
  input wire logic parEven,
  input wire logic [15:0] bitNs
);
  // Decoded frames as {parity bad, stop low, data}
  logic [9:0] rxQ[$];

  initial begin
    rxLine = 1'b1;
  end

  // Send a frame, optionally with wrong parity or a low stop bit
  task automatic sendFrame(input logic [7:0] d, input logic badPar,
                           input logic badStop);
    rxLine = 1'b0;
    #(bitNs);
    for (int i = 0; i < dataBits; i++) begin
      rxLine = d[i];
      #(bitNs);
    end
    if (parOn) begin
      rxLine = ^(d & ((8'h1 << dataBits) - 8'h1)) ^ !parEven ^ badPar;
      #(bitNs);
    end
    rxLine = !badStop;
    #(bitNs);
    rxLine = 1'b1;
    #(bitNs);
  endtask

  // Short low pulse that must not pass as a start bit
  task automatic glitch();
    rxLine = 1'b0;
    #(bitNs / 4);
    rxLine = 1'b1;
    #(bitNs);
  endtask

  // Decode transmitted frames at each bit centre
  always @(negedge txLine) begin : decode
    logic [9:0] w;
    w = 10'h0;
    #(bitNs / 2);
    if (txLine === 1'b0) begin
      for (int i = 0; i < dataBits; i++) begin
        #(bitNs);
        w[i] = txLine;
      end
      if (parOn) begin
        #(bitNs);
        w[9] = (^w[7:0]) ^ txLine ^ !parEven;
      end
      #(bitNs);
      w[8] = !txLine;
      rxQ.push_back(w);
    end
  end
endmodule // ubc_remote_model

// ---- test/tb.sv ----
// Testbench for the serial channel core
`timescale 1ns/1ps
module tb;
  import ubc_pkg::*;
  logic ref_clk, arst_n, ce, oscIn, oscOut, rxIn, txOut, txWrite, rxRead;
  logic [7:0] divisorHighByte, divisorLowByte, txData, rxData, lineStatus;
  logic fifoEnable, stopBits, parityEnable, evenParity;
  logic [1:0] wordLength, rxTrigger, intEnable;
  logic [3:0] intStatus;
  logic [15:0] bitNs;
  int errTotal, checks, n;

  ubc_uart_core ubc_uart_core_inst (.ref_clk, .arst_n, .ce, .oscIn,
    .oscOut, .rxIn, .txOut, .divisorHighByte, .divisorLowByte, .fifoEnable,
    .wordLength, .stopBits, .parityEnable, .evenParity, .rxTrigger,
    .intEnable, .txWrite, .txData, .rxRead, .rxData, .lineStatus,
    .intStatus);
  ubc_remote_model ubc_remote_model_inst (.txLine(txOut), .rxLine(rxIn),
    .dataBits({2'b0, wordLength} + 4'h5), .parOn(parityEnable),
    .parEven(evenParity), .bitNs(bitNs));

  // 250 MHz core clock and 50 MHz oscillator
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    oscIn = 1'b0;
    forever #10 oscIn = ~oscIn;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", errTotal, checks);
    if (errTotal == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait on a status bit (0..7) or the transmit line (8)
  task automatic waitOn(input int sel, input logic v, input int lim);
    n = 0;
    while ((sel == 8 ? txOut : lineStatus[sel[2:0]]) !== v) begin
      step(1);
      n++;
      if (n > lim) begin
        errTotal++;
        give_verdict();
      end
    end
  endtask

  // Back-to-back host writes, strobe held high between bytes
  task automatic writeBurst(input logic [7:0] b[$]);
    txWrite = 1'b1;
    foreach (b[i]) begin
      txData = b[i];
      step(1);
    end
    txWrite = 1'b0;
  endtask

  // Compare head byte and its tags, then pop it
  task automatic hostRead(input logic [7:0] d, input logic [2:0] tags);
    check(16'(rxData), 16'(d));
    check(16'(lineStatus[4:2]), 16'(tags));
    rxRead = 1'b1;
    step(1);
    rxRead = 1'b0;
    step(1);
  endtask

  initial begin
    {arst_n, txWrite, rxRead, fifoEnable, stopBits} = 5'b0;
    {parityEnable, evenParity, rxTrigger} = 4'b0;
    {divisorHighByte, divisorLowByte} = 16'h0001;
    ce = 1'b1;
    wordLength = 2'd3;
    intEnable = 2'b00;
    txData = 8'h00;
    bitNs = 16'd5120;
    errTotal = 0;
    checks = 0;
    step(20);
    check(16'(txOut), 16'h1);
    check(16'(lineStatus), 16'h60);
    check(16'(intStatus), 16'(IS_NONE));
    arst_n = 1'b1;
    step(3);
    // Non-FIFO 8N1 at divisor 1, both directions at once
    intEnable = 2'b10;
    step(1);
    check(16'(intStatus), 16'(IS_TXEMPTY));
    fork
      ubc_remote_model_inst.sendFrame(8'ha3, 1'b0, 1'b0);
      begin
        writeBurst('{8'h55});
        check(16'(lineStatus[6:5]), 16'h0);
        waitOn(8, 1'b0, 200);
        waitOn(8, 1'b1, 2000);
        check(16'(n >= 1278 && n <= 1282), 16'h1);
        check(16'(lineStatus[6:5]), 16'h1);
        waitOn(6, 1'b1, 12000);
        check(16'(txOut), 16'h1);
      end
    join
    check(16'(ubc_remote_model_inst.rxQ.pop_front()), 16'h55);
    intEnable = 2'b01;
    step(1);
    check(16'(intStatus), 16'(IS_RXDATA));
    hostRead(8'ha3, 3'b000);
    check(16'(intStatus), 16'(IS_NONE));
    // FIFO mode 7E1: burst write, false start and tagged errors
    fifoEnable = 1'b1;
    wordLength = 2'd2;
    parityEnable = 1'b1;
    evenParity = 1'b1;
    rxTrigger = 2'd1;
    step(1);
    fork
      begin
        ubc_remote_model_inst.glitch();
        ubc_remote_model_inst.sendFrame(8'h5a, 1'b0, 1'b0);
        ubc_remote_model_inst.sendFrame(8'h33, 1'b1, 1'b0);
        ubc_remote_model_inst.sendFrame(8'h6c, 1'b0, 1'b1);
      end
      begin
        writeBurst('{8'h41, 8'hff, 8'h00});
        check(16'(lineStatus[6:5]), 16'h0);
        waitOn(5, 1'b1, 30000);
        check(16'(lineStatus[6]), 16'h0);
        waitOn(6, 1'b1, 15000);
      end
    join
    check(16'(ubc_remote_model_inst.rxQ.pop_front()), 16'h41);
    check(16'(ubc_remote_model_inst.rxQ.pop_front()), 16'h7f);
    check(16'(ubc_remote_model_inst.rxQ.pop_front()), 16'h00);
    check(16'(intStatus), 16'(IS_NONE));
    rxTrigger = 2'd0;
    step(1);
    check(16'(intStatus), 16'(IS_RXDATA));
    hostRead(8'h5a, 3'b000);
    hostRead(8'h33, 3'b001);
    hostRead(8'h6c, 3'b010);
    check(16'(lineStatus[0]), 16'h0);
    // Non-FIFO 5-bit, two stop bits, divisor 2
    fifoEnable = 1'b0;
    wordLength = 2'd0;
    parityEnable = 1'b0;
    stopBits = 1'b1;
    divisorLowByte = 8'h02;
    bitNs = 16'd10240;
    step(1);
    fork
      ubc_remote_model_inst.sendFrame(8'h0a, 1'b0, 1'b0);
      begin
        writeBurst('{8'hf5});
        waitOn(8, 1'b0, 400);
        waitOn(8, 1'b1, 4000);
        check(16'(n >= 2558 && n <= 2562), 16'h1);
        waitOn(6, 1'b1, 25000);
      end
    join
    check(16'(ubc_remote_model_inst.rxQ.pop_front()), 16'h15);
    hostRead(8'h0a, 3'b000);
    // Host write with the baud generator stopped
    {divisorHighByte, divisorLowByte} = 16'h0000;
    step(2);
    writeBurst('{8'h7e});
    check(16'(lineStatus[6:5]), 16'h0);
    step(400);
    check(16'(lineStatus[6:5]), 16'h0);
    check(16'(txOut), 16'h1);
    give_verdict();
  end
endmodule // tb
